// file: verilog/ilv_core.sv
`timescale 1ns/1ps
`include "ilv_cfg.svh"

// Operation
// - During refresh, acknowledge a request within 118 us.
// - After acknowledge, first service instruction fetched within 16.5 us.
// - No refresh, no arithmetic option: acknowledge within 18.55 us.
// - No refresh, arithmetic option fitted: acknowledge within 27.6 us.
// - Extended instructions poll pending interrupts, abort and back up state.
// - Aborted extended instruction re-executes from start after service.
// - Same-register autostep destination: source is stepped or initial value.
// - Jump with autoincrement: new PC is initial or stepped register.
// - Jump to register mode traps illegal through vector 4 or 10.
// - Register-space program addresses time out; variant frees top sixteen.
module ilv_core
    import ilv_pkg::*;
#(
    parameter logic P_EXT_FITTED = 1'b1,
    parameter logic P_SRC_STEPPED = 1'b0,
    parameter logic P_SRC_DEF_STEPPED = 1'b0,
    parameter logic P_PC_PLUS4 = 1'b0,
    parameter logic P_JMP_STEPPED = 1'b0,
    parameter logic P_TRAP_ALT = 1'b0,
    parameter logic P_CPUREG_VALID = 1'b0,
    parameter int P_ACK_REFRESH_CYC = `ILV_ACK_REFRESH_CYC,
    parameter int P_ACK_PLAIN_CYC = `ILV_ACK_PLAIN_CYC,
    parameter int P_ACK_EXT_CYC = `ILV_ACK_EXT_CYC,
    parameter int P_FETCH_CYC = `ILV_FETCH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic interrupt_request_line,
    input wire logic event_request_line,
    input wire logic refresh_active,
    input wire logic instr_boundary,
    input wire logic ext_busy,
    input wire logic [15:0] ext_start_pc,
    input wire logic vector_ready,
    input wire logic service_return,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_pc,
    input wire logic [15:0] dst_reg_value,
    input wire logic addr_valid,
    input wire logic [15:0] prog_addr,
    output logic interrupt_acknowledge_line,
    output logic service_fetch,
    output logic ext_abort,
    output logic ext_reexec,
    output logic [15:0] restart_pc,
    output logic [15:0] src_operand,
    output logic src_override,
    output logic [15:0] stored_pc,
    output logic stored_pc_valid,
    output logic [15:0] jump_target,
    output logic jump_valid,
    output logic illegal_trap,
    output logic [15:0] trap_vector,
    output logic bus_timeout
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic irq_s, evt_s;

    ilv_sync u_sync_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(interrupt_request_line),
        .sync_out(irq_s)
    );

    ilv_sync u_sync_evt (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(event_request_line),
        .sync_out(evt_s)
    );

    logic pending;
    assign pending = irq_s | evt_s;

    // ----------------------------------------------------------------
    // Deadline counters
    // ----------------------------------------------------------------
    ilv_state_t st_q, st_d;
    logic ack_hit, fetch_hit, poll_hit;
    logic [`ILV_CNT_W-1:0] ack_limit;

    // Refresh dominates; otherwise the option sets the bound
    always_comb begin
        if (refresh_active) begin
            ack_limit = P_ACK_REFRESH_CYC[`ILV_CNT_W-1:0];
        end else if (P_EXT_FITTED) begin
            ack_limit = P_ACK_EXT_CYC[`ILV_CNT_W-1:0];
        end else begin
            ack_limit = P_ACK_PLAIN_CYC[`ILV_CNT_W-1:0];
        end
    end

    ilv_count u_ack_dl (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(st_q == ILV_WAIT),
        .clear(st_q != ILV_WAIT),
        .limit(ack_limit),
        .hit(ack_hit)
    );

    ilv_count u_fetch_dl (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(st_q == ILV_ACK),
        .clear(st_q != ILV_ACK),
        .limit(P_FETCH_CYC[`ILV_CNT_W-1:0]),
        .hit(fetch_hit)
    );

    // Periodic scan tick for long arithmetic
    ilv_count u_poll (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(1'b1),
        .clear(poll_hit),
        .limit(16'(`ILV_POLL_CYC)),
        .hit(poll_hit)
    );

    // ----------------------------------------------------------------
    // Interrupt sequencer
    // ----------------------------------------------------------------
    logic restart_q, restart_d;
    logic [15:0] rpc_q, rpc_d;
    logic abort_now;

    // Abort only on a scan tick, never mid-scan, so state backs up cleanly
    assign abort_now = P_EXT_FITTED && ext_busy && poll_hit && pending;

    always_comb begin
        st_d = st_q;
        restart_d = restart_q;
        rpc_d = rpc_q;
        case (st_q)
            ILV_IDLE: begin
                if (irq_s) begin
                    st_d = ILV_WAIT;
                end
            end
            ILV_WAIT: begin
                if (abort_now) begin
                    restart_d = 1'b1;
                    rpc_d = ext_start_pc;
                    st_d = ILV_ACK;
                end else if ((instr_boundary && !ext_busy) || ack_hit) begin
                    st_d = ILV_ACK;
                end
            end
            ILV_ACK: begin
                if (vector_ready || fetch_hit) begin
                    st_d = ILV_SERVICE;
                end
            end
            ILV_SERVICE: begin
                if (service_return) begin
                    restart_d = 1'b0;
                    st_d = ILV_IDLE;
                end
            end
            default: begin
                st_d = ILV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= ILV_IDLE;
            restart_q <= 1'b0;
            rpc_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            restart_q <= restart_d;
            rpc_q <= rpc_d;
        end
    end

    assign interrupt_acknowledge_line = (st_q == ILV_ACK);
    assign service_fetch = (st_q == ILV_ACK) && (vector_ready || fetch_hit);
    assign ext_abort = (st_q == ILV_WAIT) && abort_now;
    assign ext_reexec = (st_q == ILV_SERVICE) && service_return && restart_q;
    assign restart_pc = rpc_q;

    // ----------------------------------------------------------------
    // Instruction variant decode
    // ----------------------------------------------------------------
    ilv_mode_t src_mode, dst_mode;
    logic [2:0] src_reg, dst_reg;
    logic is_dop, is_jmp, is_jsr, is_jump, same_reg;
    logic [15:0] reg_inc, reg_dec;

    assign src_mode = ilv_mode_t'(instr_word[11:9]);
    assign src_reg = instr_word[8:6];
    assign dst_mode = ilv_mode_t'(instr_word[5:3]);
    assign dst_reg = instr_word[2:0];
    assign is_dop = (instr_word[14:12] != 3'h0) && (instr_word[14:12] != 3'h7);
    assign is_jmp = (instr_word[15:6] == `ILV_JMP_OPC);
    assign is_jsr = (instr_word[15:9] == `ILV_JSR_OPC);
    assign is_jump = is_jmp || is_jsr;
    assign same_reg = (src_mode == ILV_M_REG) && (src_reg == dst_reg);
    assign reg_inc = dst_reg_value + `ILV_STEP;
    assign reg_dec = dst_reg_value - `ILV_STEP;

    logic [15:0] src_d, spc_d, jt_d, vec_d;
    logic srcv_d, spcv_d, jv_d, trap_d, tmo_d;

    always_comb begin
        src_d = dst_reg_value;
        srcv_d = 1'b0;
        spc_d = instr_pc + `ILV_PC_STEP_SHORT;
        spcv_d = 1'b0;
        jt_d = dst_reg_value;
        jv_d = 1'b0;
        trap_d = 1'b0;
        vec_d = `ILV_TRAP_VEC_STD;
        if (instr_valid && is_dop && same_reg) begin
            case (dst_mode)
                ILV_M_AINC: begin
                    src_d = P_SRC_STEPPED ? reg_inc : dst_reg_value;
                    srcv_d = 1'b1;
                end
                ILV_M_ADEC: begin
                    src_d = P_SRC_STEPPED ? reg_dec : dst_reg_value;
                    srcv_d = 1'b1;
                end
                ILV_M_AINC_D: begin
                    src_d = P_SRC_DEF_STEPPED ? reg_inc : dst_reg_value;
                    srcv_d = 1'b1;
                end
                ILV_M_ADEC_D: begin
                    src_d = P_SRC_DEF_STEPPED ? reg_dec : dst_reg_value;
                    srcv_d = 1'b1;
                end
                default: begin
                    srcv_d = 1'b0;
                end
            endcase
        end
        // Indexed modes, plus absolute (mode 3 on the PC)
        if (instr_valid && is_dop && (src_mode == ILV_M_REG) && (src_reg == `ILV_PC_REG)
            && ((dst_mode == ILV_M_INDEX) || (dst_mode == ILV_M_INDEX_D)
            || ((dst_mode == ILV_M_AINC_D) && (dst_reg == `ILV_PC_REG)))) begin
            spc_d = instr_pc + (P_PC_PLUS4 ? `ILV_PC_STEP_LONG : `ILV_PC_STEP_SHORT);
            spcv_d = 1'b1;
        end
        if (instr_valid && is_jump) begin
            if (dst_mode == ILV_M_REG) begin
                trap_d = 1'b1;
                vec_d = P_TRAP_ALT ? `ILV_TRAP_VEC_ALT : `ILV_TRAP_VEC_STD;
            end else if (dst_mode == ILV_M_AINC) begin
                jt_d = P_JMP_STEPPED ? reg_inc : dst_reg_value;
                jv_d = 1'b1;
            end
        end
        // Register page times out unless the CPU-register window is allowed
        if (addr_valid && (prog_addr >= `ILV_REGSPACE_LO) && (prog_addr <= `ILV_REGSPACE_HI)) begin
            tmo_d = !(P_CPUREG_VALID && (prog_addr >= `ILV_CPUREG_LO));
        end else begin
            tmo_d = 1'b0;
        end
    end

    logic [15:0] src_q, spc_q, jt_q, vec_q;
    logic srcv_q, spcv_q, jv_q, trap_q, tmo_q;

    // Variants are elaboration constants only; nothing here changes them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_q <= 16'h0000;
            srcv_q <= 1'b0;
            spc_q <= 16'h0000;
            spcv_q <= 1'b0;
            jt_q <= 16'h0000;
            jv_q <= 1'b0;
            trap_q <= 1'b0;
            vec_q <= `ILV_TRAP_VEC_STD;
            tmo_q <= 1'b0;
        end else begin
            src_q <= src_d;
            srcv_q <= srcv_d;
            spc_q <= spc_d;
            spcv_q <= spcv_d;
            jt_q <= jt_d;
            jv_q <= jv_d;
            trap_q <= trap_d;
            vec_q <= vec_d;
            tmo_q <= tmo_d;
        end
    end

    assign src_operand = src_q;
    assign src_override = srcv_q;
    assign stored_pc = spc_q;
    assign stored_pc_valid = spcv_q;
    assign jump_target = jt_q;
    assign jump_valid = jv_q;
    assign illegal_trap = trap_q;
    assign trap_vector = vec_q;
    assign bus_timeout = tmo_q;

endmodule : ilv_core

// file: verilog/ilv_cfg.svh
`ifndef ILV_CFG_SVH
`define ILV_CFG_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define ILV_CLK_PERIOD_NS 4

// ----------------------------------------------------------------
// Latency bounds in ns
// ----------------------------------------------------------------
`define ILV_ACK_REFRESH_NS 118000
`define ILV_ACK_PLAIN_NS 18550
`define ILV_ACK_EXT_NS 27600
`define ILV_FETCH_NS 16500
`define ILV_POLL_NS 1000

// Longest times round down to whole cycles
`define ILV_ACK_REFRESH_CYC (`ILV_ACK_REFRESH_NS / `ILV_CLK_PERIOD_NS)
`define ILV_ACK_PLAIN_CYC (`ILV_ACK_PLAIN_NS / `ILV_CLK_PERIOD_NS)
`define ILV_ACK_EXT_CYC (`ILV_ACK_EXT_NS / `ILV_CLK_PERIOD_NS)
`define ILV_FETCH_CYC (`ILV_FETCH_NS / `ILV_CLK_PERIOD_NS)
`define ILV_POLL_CYC (`ILV_POLL_NS / `ILV_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Instruction fields and addresses
// ----------------------------------------------------------------
`define ILV_STEP 16'h0002
`define ILV_PC_STEP_LONG 16'h0004
`define ILV_PC_STEP_SHORT 16'h0002
`define ILV_TRAP_VEC_STD 16'h0004
`define ILV_TRAP_VEC_ALT 16'h0008
`define ILV_PC_REG 3'h7
`define ILV_JMP_OPC 10'h001
`define ILV_JSR_OPC 7'h04
`define ILV_REGSPACE_LO 16'hFE00
`define ILV_REGSPACE_HI 16'hFFCF
`define ILV_CPUREG_LO 16'hFFC0
`define ILV_CNT_W 16

`endif

// file: verilog/ilv_pkg.sv
package ilv_pkg;

    // ----------------------------------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ILV_IDLE    = 4'h1,
        ILV_WAIT    = 4'h2,
        ILV_ACK     = 4'h4,
        ILV_SERVICE = 4'h8
    } ilv_state_t;

    // ----------------------------------------------------------------
    // Operand addressing modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ILV_M_REG     = 3'h0,
        ILV_M_DEF     = 3'h1,
        ILV_M_AINC    = 3'h2,
        ILV_M_AINC_D  = 3'h3,
        ILV_M_ADEC    = 3'h4,
        ILV_M_ADEC_D  = 3'h5,
        ILV_M_INDEX   = 3'h6,
        ILV_M_INDEX_D = 3'h7
    } ilv_mode_t;

endpackage : ilv_pkg

// file: verilog/ilv_sync.sv
`timescale 1ns/1ps
`include "ilv_cfg.svh"

module ilv_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : ilv_sync

// file: verilog/ilv_count.sv
`timescale 1ns/1ps
`include "ilv_cfg.svh"

module ilv_count (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic clear,
    input wire logic [`ILV_CNT_W-1:0] limit,
    output logic hit
);
    logic [`ILV_CNT_W-1:0] cnt_q, cnt_d;

    // Saturates at limit-1 so hit stays up until cleared
    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = '0;
        end else if (run && !hit) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Compare, not equality: a limit that drops below the count still hits at once
    assign hit = (cnt_q >= limit - 16'h0001);
endmodule : ilv_count

// file: sim/ilv_core_assertions.sv
`timescale 1ns/1ps
module ilv_core_assertions #(
    parameter int P_ACK_REFRESH_CYC = 400,
    parameter int P_FETCH_CYC = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic interrupt_request_line,
    input wire logic service_return,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_pc,
    input wire logic [15:0] dst_reg_value,
    input wire logic addr_valid,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] ext_start_pc,
    input wire logic interrupt_acknowledge_line,
    input wire logic service_fetch,
    input wire logic ext_abort,
    input wire logic ext_reexec,
    input wire logic [15:0] restart_pc,
    input wire logic [15:0] stored_pc,
    input wire logic stored_pc_valid,
    input wire logic [15:0] jump_target,
    input wire logic jump_valid,
    input wire logic illegal_trap,
    input wire logic [15:0] trap_vector,
    input wire logic bus_timeout
);
    // ----
    // Request wait counter
    // ----
    localparam int FETCH_MAX = P_FETCH_CYC + 2;
    localparam int ACK_MAX = P_ACK_REFRESH_CYC + 6;
    logic [15:0] wait_d;
    logic [15:0] wait_q;
    logic jmp_op;
    logic pc_src;
    logic seen_d;
    logic seen_q;
    assign jmp_op = instr_valid && instr_word[15:6] == 10'h001;
    assign pc_src = instr_valid && instr_word[14:12] != 3'h0 && instr_word[14:12] != 3'h7;
    always_comb begin
        wait_d = 16'h0000;
        seen_d = ext_abort || (seen_q && !service_return);
        if (interrupt_request_line && !interrupt_acknowledge_line) begin
            wait_d = wait_q + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys) begin
        wait_q <= rst ? 16'h0000 : wait_d;
        seen_q <= rst ? 1'b0 : seen_d;
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_ack_rise;
        $rose(interrupt_acknowledge_line);
    endsequence
    sequence s_fetch_soon;
        ##[0:FETCH_MAX] service_fetch;
    endsequence
    a_fetch_bound: assert property (s_ack_rise |-> s_fetch_soon)
        else $error("service fetch late");
    a_ack_release: assert property (service_fetch |=> !interrupt_acknowledge_line)
        else $error("ack held after fetch");
    a_ack_bound: assert property (wait_q <= ACK_MAX)
        else $error("ack late");
    a_abort_ack: assert property (ext_abort |=> interrupt_acknowledge_line)
        else $error("no ack after abort");
    a_restart_pc: assert property (ext_abort |=> restart_pc == $past(ext_start_pc))
        else $error("restart address wrong");
    a_reexec_ret: assert property (service_return |-> ext_reexec == seen_q)
        else $error("reexec does not match abort");
    a_jump_trap: assert property (instr_valid && instr_word[5:3] == 3'h0 &&
        (jmp_op || instr_word[15:9] == 7'h04) |=> illegal_trap && trap_vector == 16'h0004)
        else $error("jump register mode not trapped");
    a_jump_tgt: assert property (jmp_op && instr_word[5:3] == 3'h2 |=>
        jump_valid && jump_target == $past(dst_reg_value))
        else $error("jump target wrong");
    a_pc_store: assert property (pc_src && instr_word[11:6] == 6'h07 &&
        (instr_word[5:4] == 2'h3 || instr_word[5:0] == 6'h1F) |=>
        stored_pc_valid && stored_pc == $past(instr_pc) + 16'h0002)
        else $error("stored pc wrong");
    a_bus_timeout: assert property (addr_valid |=> bus_timeout ==
        ($past(prog_addr) >= 16'hFE00 && $past(prog_addr) <= 16'hFFCF))
        else $error("bus timeout wrong");
endmodule : ilv_core_assertions

bind ilv_core ilv_core_assertions #(
    .P_ACK_REFRESH_CYC(P_ACK_REFRESH_CYC),
    .P_FETCH_CYC(P_FETCH_CYC)
) ilv_core_assertions_inst (.clk_sys, .rst, .interrupt_request_line, .service_return,
    .instr_valid, .instr_word, .instr_pc, .dst_reg_value, .addr_valid, .prog_addr,
    .ext_start_pc, .interrupt_acknowledge_line, .service_fetch, .ext_abort, .ext_reexec,
    .restart_pc, .stored_pc, .stored_pc_valid, .jump_target, .jump_valid, .illegal_trap,
    .trap_vector, .bus_timeout);

// file: sim/ilv_periph.sv
`timescale 1ns/1ps
module ilv_periph (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic raise,
    input wire logic interrupt_acknowledge_line,
    output logic interrupt_request_line,
    output logic event_request_line
);
    // ----
    // Request holds until acknowledged
    // ----
    logic req_d;
    logic req_q;
    always_comb begin
        req_d = req_q;
        if (raise) begin
            req_d = 1'b1;
        end
        if (interrupt_acknowledge_line) begin
            req_d = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        req_q <= rst ? 1'b0 : req_d;
    end
    assign interrupt_request_line = req_q;
    // Quiet event input: zero rate stays inside both rate limits
    assign event_request_line = 1'b0;
endmodule : ilv_periph

// file: sim/interrupt_latency_and_isa_variants_tb.sv
`timescale 1ns/1ps
module interrupt_latency_and_isa_variants_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic raise = 1'b0;
    logic refresh_active = 1'b0;
    logic instr_boundary = 1'b0;
    logic ext_busy = 1'b0;
    logic vector_ready = 1'b0;
    logic service_return = 1'b0;
    logic instr_valid = 1'b0;
    logic addr_valid = 1'b0;
    logic [15:0] ext_start_pc = 16'h0000;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] instr_pc = 16'h0100;
    logic [15:0] dst_reg_value = 16'h0000;
    logic [15:0] prog_addr = 16'h0000;
    logic interrupt_request_line, event_request_line, interrupt_acknowledge_line;
    logic service_fetch, ext_abort, ext_reexec, src_override, stored_pc_valid;
    logic jump_valid, illegal_trap, bus_timeout;
    logic [15:0] restart_pc, src_operand, stored_pc, jump_target, trap_vector;
    int fails = 0;
    int checks_done = 0;

    // Short latency limits keep the run brief
    ilv_core #(.P_ACK_REFRESH_CYC(400), .P_ACK_PLAIN_CYC(20), .P_ACK_EXT_CYC(300),
        .P_FETCH_CYC(16)) ilv_core_inst (.clk_sys, .rst, .interrupt_request_line,
        .event_request_line, .refresh_active, .instr_boundary, .ext_busy, .ext_start_pc,
        .vector_ready, .service_return, .instr_valid, .instr_word, .instr_pc,
        .dst_reg_value, .addr_valid, .prog_addr, .interrupt_acknowledge_line,
        .service_fetch, .ext_abort, .ext_reexec, .restart_pc, .src_operand, .src_override,
        .stored_pc, .stored_pc_valid, .jump_target, .jump_valid, .illegal_trap,
        .trap_vector, .bus_timeout);
    ilv_periph ilv_periph_inst (.clk_sys, .rst, .raise, .interrupt_acknowledge_line,
        .interrupt_request_line, .event_request_line);

    // ----
    // Shared tasks
    // ----
    task automatic cmp_val(input logic [15:0] g, input logic [15:0] e, input string w);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask : cmp_val
    task automatic cmp_bit(input logic g, input logic e, input string w);
        cmp_val({15'h0000, g}, {15'h0000, e}, w);
    endtask : cmp_bit
    function automatic logic pick(input int s);
        return s == 0 ? interrupt_acknowledge_line : s == 1 ? service_fetch : ext_abort;
    endfunction : pick
    task automatic wait_on(input int s, input int lim, output int n);
        n = 0;
        #1;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : wait_on
    task automatic request();
        @(posedge clk_sys);
        raise <= 1'b1;
        @(posedge clk_sys);
        raise <= 1'b0;
    endtask : request
    task automatic serve(input logic vec, input logic rx);
        int n;
        @(posedge clk_sys);
        vector_ready <= vec;
        wait_on(1, 20, n);
        cmp_bit(service_fetch, 1'b1, "fetch");
        @(posedge clk_sys);
        vector_ready <= 1'b0;
        #1;
        cmp_bit(interrupt_acknowledge_line, 1'b0, "ack drop");
        @(posedge clk_sys);
        service_return <= 1'b1;
        #1;
        cmp_bit(ext_reexec, rx, "reexec");
        @(posedge clk_sys);
        service_return <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : serve
    task automatic dec(input logic [15:0] w, input logic [15:0] d);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        dst_reg_value <= d;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask : dec

    // ----
    // Scenarios
    // ----
    task automatic t_boundary();
        int n;
        request();
        repeat (6) @(posedge clk_sys);
        instr_boundary <= 1'b1;
        @(posedge clk_sys);
        instr_boundary <= 1'b0;
        wait_on(0, 4, n);
        cmp_bit(interrupt_acknowledge_line, 1'b1, "boundary ack");
        serve(1'b1, 1'b0);
        $display("test boundary done");
    endtask : t_boundary
    task automatic t_refresh(input logic refr, input int bound);
        int n;
        refresh_active <= refr;
        request();
        wait_on(0, 420, n);
        cmp_bit(n <= bound, 1'b1, "deadline ack bound");
        @(posedge clk_sys);
        refresh_active <= 1'b0;
        serve(1'b0, 1'b0);
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_abort();
        int n;
        @(posedge clk_sys);
        ext_busy <= 1'b1;
        ext_start_pc <= 16'h1234;
        request();
        wait_on(2, 260, n);
        cmp_bit(ext_abort, 1'b1, "abort");
        @(posedge clk_sys);
        ext_busy <= 1'b0;
        #1;
        cmp_val(restart_pc, 16'h1234, "restart pc");
        serve(1'b1, 1'b1);
        $display("test abort done");
    endtask : t_abort
    task automatic t_decode();
        logic [15:0] at [5] = '{16'hFE00, 16'hFFC0, 16'hFFCF, 16'hFFD0, 16'hFDFF};
        logic ae [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        dec(16'h0041, 16'h0000);
        cmp_val(trap_vector, 16'h0004, "jmp reg vector");
        cmp_bit(illegal_trap, 1'b1, "jmp reg trap");
        dec(16'h09C1, 16'h0000);
        cmp_bit(illegal_trap, 1'b1, "jsr reg trap");
        cmp_val(trap_vector, 16'h0004, "jsr reg vector");
        dec(16'h0052, 16'h2000);
        cmp_val(jump_target, 16'h2000, "jmp autoinc");
        cmp_bit(jump_valid, 1'b1, "jmp autoinc valid");
        cmp_bit(illegal_trap, 1'b0, "jmp autoinc no trap");
        dec(16'h11F7, 16'h0000);
        cmp_val(stored_pc, 16'h0102, "pc store");
        cmp_bit(stored_pc_valid, 1'b1, "pc store valid");
        dec(16'h11DF, 16'h0000);
        cmp_val(stored_pc, 16'h0102, "pc store absolute");
        cmp_bit(stored_pc_valid, 1'b1, "pc absolute valid");
        dec(16'h11C1, 16'h0000);
        cmp_bit(stored_pc_valid, 1'b0, "pc to register");
        dec(16'h1051, 16'h0300);
        cmp_val(src_operand, 16'h0300, "same reg src");
        cmp_bit(src_override, 1'b1, "same reg override");
        dec(16'h1061, 16'h0300);
        cmp_val(src_operand, 16'h0300, "same reg dec src");
        cmp_bit(src_override, 1'b1, "same reg dec override");
        dec(16'h1091, 16'h0300);
        cmp_bit(src_override, 1'b0, "other reg override");
        dec(16'h1059, 16'h0300);
        cmp_val(src_operand, 16'h0300, "deferred src");
        cmp_bit(src_override, 1'b1, "deferred override");
        dec(16'h1069, 16'h0300);
        cmp_val(src_operand, 16'h0300, "deferred dec src");
        cmp_bit(src_override, 1'b1, "deferred dec override");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            addr_valid <= 1'b1;
            prog_addr <= at[i];
            @(posedge clk_sys);
            addr_valid <= 1'b0;
            #1;
            cmp_bit(bus_timeout, ae[i], "timeout");
        end
        $display("test decode done");
    endtask : t_decode
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_boundary();
        t_refresh(1'b1, 406);
        t_refresh(1'b0, 306);
        t_abort();
        t_decode();
        end_sim();
    end
    initial begin
        #40000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end
endmodule : interrupt_latency_and_isa_variants_tb
